// ===== hw/ras_ctl.sv
// controller end: retrying access master with sequencing guards
`timescale 1ns/10ps
module ras_ctl (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// control channel and pins
	ras_if.ctl bus,
	// command from firmware
	input wire logic i_cmd_valid,
	input wire logic i_cmd_src_up,
	input wire logic i_cmd_we,
	input wire logic [7:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_wdata,
	output logic o_cmd_ready,
	// command result
	output logic o_done,
	output logic o_fail,
	output logic o_refused,
	output logic [7:0] o_rdata,
	// sequencing status
	input wire logic [7:0] i_list_bytes,
	input wire logic i_hash_check,
	input wire logic i_hash_match,
	input wire logic i_revoked,
	output logic o_pin1_seen,
	output logic o_pin0_seen,
	output logic o_auth_fail,
	output logic o_protected_ok
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	ras_pkg::ras_mst_t st_reg;
	logic src_reg, we_reg;
	logic [7:0] addr_reg, wdata_reg, rdata_reg;
	logic [3:0] wait_reg;
	logic [2:0] try_reg;
	logic done_reg, fail_reg, refused_reg;
	logic [7:0] list_cnt_reg;
	logic ready_set_reg;
	logic blocked_reg;
	logic [2:0] vs_reg, p0_reg, p1_reg;
	logic vs_filt_reg, vs_seen_reg;
	logic fail_auth_reg, match_reg;
	logic [1:0] cmp_reg;
	logic bad;

	// --------------------------------------------------------------
	// pin sampling
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			vs_reg <= 3'b000;
			p0_reg <= 3'b000;
			p1_reg <= 3'b000;
			vs_filt_reg <= 1'b0;
		end else begin
			vs_reg <= {vs_reg[1:0], bus.vsync};
			p0_reg <= {p0_reg[1:0], bus.gpio0_o && !bus.gpio0_oe_n};
			p1_reg <= {p1_reg[1:0], bus.gpio1_o && !bus.gpio1_oe_n};
			if (vs_reg[1] == vs_reg[2]) begin
				vs_filt_reg <= vs_reg[2];
			end
		end
	end
	assign o_pin1_seen = p1_reg[1] && p1_reg[2];
	assign o_pin0_seen = p0_reg[1] && p0_reg[2];

	// --------------------------------------------------------------
	// guards
	// --------------------------------------------------------------
	// host encryption only after vsync fall; topology after full list;
	// channel re-enable only after ready flag written
	always_comb begin
		bad = 1'b0;
		if (i_cmd_we && i_cmd_addr == ras_pkg::RAS_CTRL_ADDR) begin
			if (i_cmd_wdata[ras_pkg::RAS_ENC_BIT] && i_cmd_src_up &&
				!vs_seen_reg) begin
				bad = 1'b1;
			end
			if (!i_cmd_src_up && i_cmd_wdata[1:0] == 2'b11 &&
				blocked_reg && !ready_set_reg) begin
				bad = 1'b1;
			end
		end
		if (i_cmd_we && i_cmd_addr == ras_pkg::RAS_TOPO_HI_ADDR &&
			list_cnt_reg < i_list_bytes) begin
			bad = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			vs_seen_reg <= 1'b0;
			list_cnt_reg <= 8'h00;
			ready_set_reg <= 1'b0;
			blocked_reg <= 1'b0;
		end else begin
			if (vs_filt_reg && !vs_reg[1] && !vs_reg[2]) begin
				vs_seen_reg <= 1'b1;
			end
			if (done_reg && we_reg) begin
				if (addr_reg[7]) begin
					list_cnt_reg <= list_cnt_reg + 8'h01;
				end else if (addr_reg == ras_pkg::RAS_TOPO_HI_ADDR) begin
					list_cnt_reg <= 8'h00;
				end else if (addr_reg == ras_pkg::RAS_STAT_ADDR) begin
					ready_set_reg <= wdata_reg[ras_pkg::RAS_READY_BIT];
				end else if (addr_reg == ras_pkg::RAS_CTRL_ADDR) begin
					// only a fully blocked channel waits for the ready flag
					blocked_reg <= wdata_reg[1:0] == 2'b00;
					if (wdata_reg[1:0] == 2'b11) begin
						ready_set_reg <= 1'b0;
					end
				end
			end
		end
	end

	// --------------------------------------------------------------
	// access engine with retry
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= ras_pkg::RAS_M_IDLE;
			src_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wait_reg <= 4'h0;
			try_reg <= 3'h0;
		end else begin
			case (st_reg)
				ras_pkg::RAS_M_IDLE: begin
					if (i_cmd_valid && !bad) begin
						src_reg <= i_cmd_src_up;
						we_reg <= i_cmd_we;
						addr_reg <= i_cmd_addr;
						wdata_reg <= i_cmd_wdata;
						try_reg <= 3'h1;
						wait_reg <= 4'h0;
						st_reg <= ras_pkg::RAS_M_WAIT;
					end
				end
				ras_pkg::RAS_M_WAIT: begin
					wait_reg <= wait_reg + 4'h1;
					if (bus.ack) begin
						st_reg <= ras_pkg::RAS_M_IDLE;
					end else if (wait_reg == 4'(ras_pkg::RAS_ACK_WAIT)) begin
						// repeat until acknowledged or RAS_MAX_TRIES tries spent
						if (try_reg == 3'(ras_pkg::RAS_MAX_TRIES)) begin
							st_reg <= ras_pkg::RAS_M_IDLE;
						end else begin
							try_reg <= try_reg + 3'h1;
							wait_reg <= 4'h0;
							st_reg <= ras_pkg::RAS_M_GAP;
						end
					end
				end
				ras_pkg::RAS_M_GAP: st_reg <= ras_pkg::RAS_M_WAIT;
				default: st_reg <= ras_pkg::RAS_M_IDLE;
			endcase
		end
	end
	assign bus.req = st_reg == ras_pkg::RAS_M_WAIT && wait_reg == 4'h0;
	assign bus.src_up = src_reg;
	assign bus.we = we_reg;
	assign bus.addr = addr_reg;
	assign bus.wdata = wdata_reg;
	assign o_cmd_ready = st_reg == ras_pkg::RAS_M_IDLE;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			refused_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			done_reg <= st_reg == ras_pkg::RAS_M_WAIT && bus.ack;
			fail_reg <= st_reg == ras_pkg::RAS_M_WAIT && !bus.ack &&
				wait_reg == 4'(ras_pkg::RAS_ACK_WAIT) &&
				try_reg == 3'(ras_pkg::RAS_MAX_TRIES);
			refused_reg <= o_cmd_ready && i_cmd_valid && bad;
			if (st_reg == ras_pkg::RAS_M_WAIT && bus.ack && !we_reg) begin
				rdata_reg <= bus.rdata;
			end
		end
	end
	assign o_done = done_reg;
	assign o_fail = fail_reg;
	assign o_refused = refused_reg;
	assign o_rdata = rdata_reg;

	// --------------------------------------------------------------
	// second-part verdict
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fail_auth_reg <= 1'b0;
			match_reg <= 1'b0;
			cmp_reg <= 2'h0;
		end else begin
			if (done_reg && !we_reg) begin
				if (addr_reg == ras_pkg::RAS_TOPO_LO_ADDR &&
					bus.rdata[ras_pkg::RAS_DEV_EXC_BIT]) begin
					fail_auth_reg <= 1'b1;
				end
				if (addr_reg == ras_pkg::RAS_TOPO_HI_ADDR &&
					bus.rdata[ras_pkg::RAS_DEPTH_EXC_BIT]) begin
					fail_auth_reg <= 1'b1;
				end
			end
			if (i_hash_check && !match_reg && !fail_auth_reg) begin
				if (i_hash_match) begin
					match_reg <= 1'b1;
				end else if (cmp_reg == 2'(ras_pkg::RAS_MAX_COMPARES - 1)) begin
					fail_auth_reg <= 1'b1;
				end else begin
					cmp_reg <= cmp_reg + 2'h1;
				end
			end
		end
	end
	assign o_auth_fail = fail_auth_reg;
	assign o_protected_ok = match_reg && !fail_auth_reg && !i_revoked;
endmodule

// ===== hw/ras_if.sv
// control-channel carrier between the receiver and the controllers
`timescale 1ns/10ps
interface ras_if;
	logic req;
	logic src_up;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	logic vsync;
	logic gpio0_o;
	logic gpio0_oe_n;
	logic gpio1_o;
	logic gpio1_oe_n;
	modport rx (input req, src_up, we, addr, wdata, vsync,
		output ack, rdata, gpio0_o, gpio0_oe_n, gpio1_o, gpio1_oe_n);
	modport ctl (output req, src_up, we, addr, wdata,
		input ack, rdata, vsync, gpio0_o, gpio0_oe_n, gpio1_o,
		gpio1_oe_n);
endinterface

// ===== hw/ras_pkg.sv
// shared constants and types for the repeater authentication sequencer
package ras_pkg;
	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] RAS_CTRL_ADDR = 8'h00;
	localparam logic [7:0] RAS_STAT_ADDR = 8'h01;
	localparam logic [7:0] RAS_SECRET_ADDR = 8'h03;
	localparam logic [7:0] RAS_TOPO_LO_ADDR = 8'h04;
	localparam logic [7:0] RAS_TOPO_HI_ADDR = 8'h05;
	localparam logic [7:0] RAS_HASH0_ADDR = 8'h06;
	localparam logic [7:0] RAS_TXKEY0_ADDR = 8'h10;
	localparam logic [7:0] RAS_TXKEY_LAST_ADDR = 8'h14;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int RAS_FWD_BIT = 0;
	localparam int RAS_REV_BIT = 1;
	localparam int RAS_ENC_BIT = 2;
	localparam int RAS_PIN0_SEL_BIT = 3;
	localparam int RAS_PIN1_SEL_BIT = 4;
	localparam int RAS_READY_BIT = 0;
	localparam int RAS_FLAG_A_BIT = 1;
	localparam int RAS_DECRYPT_BIT = 2;
	localparam int RAS_BUSY_BIT = 3;
	localparam int RAS_DEV_EXC_BIT = 7;
	localparam int RAS_DEPTH_EXC_BIT = 3;
	localparam int RAS_LIST_IDX_W = 7;
	localparam int RAS_KEY_BYTES = 5;
	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [7:0] RAS_CTRL_RST = 8'h03;
	localparam logic [31:0] RAS_HASH_SEED = 32'h0000_0001;
	localparam int RAS_ACK_WAIT = 8;
	localparam int RAS_MAX_TRIES = 4;
	localparam int RAS_MAX_COMPARES = 3;
	typedef enum logic [1:0] {
		RAS_M_IDLE = 2'b00,
		RAS_M_WAIT = 2'b01,
		RAS_M_GAP = 2'b10
	} ras_mst_t;
endpackage

// ===== hw/ras_rx.sv
// repeater input receiver: key list, topology hash, channel gating
// Overview of operation
// - decryption switches on at next vsync fall
// - host waits vsync fall before enabling encryption
// - both channel enables zero blocks upstream traffic
// - both channel enables one resumes upstream traffic
// - local controller retries blocking write until acknowledged; the controller gives up after four tries
// - topology write starts hash over list
// - local controller writes key list then topology
// - topology always written after complete key list
// - host polls list-ready flag until read one
// - ready flag set before channel enables restored
// - host fails when count or depth exceeded
// - hash mismatch retried at most two more times
// - downstream part one starts after pin one high
// - downstream encryption starts after pin zero high
// - no revoked key allowed for completion
// - protected content only after part two done
// - transmitter key write sets started flag, pin one
// - pin zero follows encryption enable bit
// - controller selects both pin functions first
`timescale 1ns/10ps
module ras_rx (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// control channel and pins
	ras_if.rx bus,
	// local status
	output logic o_decrypt_active,
	output logic o_hash_busy
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic ready_reg;
	logic flag_a_reg;
	logic [7:0] secret_reg;
	logic [15:0] topo_reg;
	logic [31:0] hash_reg;
	logic [7:0] list_mem [0:127];
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic enc_pend_reg;
	logic decrypt_reg;
	logic busy_reg;
	logic [7:0] hidx_reg;
	logic [7:0] hlen_reg;
	logic [2:0] vs_sync_reg;
	logic vs_filt_reg;
	logic take;
	logic wr;
	logic vs_fall;
	logic [7:0] hbyte;

	// --------------------------------------------------------------
	// access gating
	// --------------------------------------------------------------
	// upstream requests need the forward path, answers the reverse
	assign take = bus.req &&
		(!bus.src_up || ctrl_reg[ras_pkg::RAS_FWD_BIT]);
	assign wr = take && bus.we;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take && (!bus.src_up ||
				ctrl_reg[ras_pkg::RAS_REV_BIT]);
		end
	end
	assign bus.ack = ack_reg;
	assign bus.rdata = rdata_reg;

	// --------------------------------------------------------------
	// control register
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_reg <= ras_pkg::RAS_CTRL_RST;
		end else if (wr && bus.addr == ras_pkg::RAS_CTRL_ADDR) begin
			ctrl_reg <= {3'h0, bus.wdata[4:0]};
		end
	end

	// --------------------------------------------------------------
	// status flags
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ready_reg <= 1'b0;
		end else if (wr && bus.addr == ras_pkg::RAS_STAT_ADDR) begin
			ready_reg <= bus.wdata[ras_pkg::RAS_READY_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_a_reg <= 1'b0;
		end else if (wr && bus.addr == ras_pkg::RAS_TXKEY_LAST_ADDR) begin
			flag_a_reg <= 1'b1;
		end else if (wr && bus.addr == ras_pkg::RAS_STAT_ADDR) begin
			flag_a_reg <= bus.wdata[ras_pkg::RAS_FLAG_A_BIT];
		end
	end

	// --------------------------------------------------------------
	// secret, topology and key list
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			secret_reg <= 8'h00;
		end else if (wr && bus.addr == ras_pkg::RAS_SECRET_ADDR) begin
			secret_reg <= bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			topo_reg <= 16'h0000;
		end else if (wr && bus.addr == ras_pkg::RAS_TOPO_LO_ADDR) begin
			topo_reg[7:0] <= bus.wdata;
		end else if (wr && bus.addr == ras_pkg::RAS_TOPO_HI_ADDR) begin
			topo_reg[15:8] <= bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (wr && bus.addr[7]) begin
			list_mem[bus.addr[6:0]] <= bus.wdata;
		end
	end

	// --------------------------------------------------------------
	// hash engine
	// --------------------------------------------------------------
	// walks the listed bytes, then folds in topology and secret
	always_comb begin
		hbyte = list_mem[hidx_reg[6:0]];
		if (hidx_reg == hlen_reg) begin
			hbyte = topo_reg[7:0] ^ topo_reg[15:8] ^ secret_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_reg <= 1'b0;
			hidx_reg <= 8'h00;
			hlen_reg <= 8'h00;
			hash_reg <= ras_pkg::RAS_HASH_SEED;
		end else if (wr && bus.addr == ras_pkg::RAS_TOPO_HI_ADDR) begin
			busy_reg <= 1'b1;
			hidx_reg <= 8'h00;
			hlen_reg <= 8'(topo_reg[6:0] * 7'(ras_pkg::RAS_KEY_BYTES));
			hash_reg <= ras_pkg::RAS_HASH_SEED;
		end else if (busy_reg) begin
			hash_reg <= {hash_reg[26:0], hash_reg[31:27]} ^
				{24'h00_0000, hbyte};
			hidx_reg <= hidx_reg + 8'h01;
			if (hidx_reg == hlen_reg) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// read mux
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= 8'h00;
		end else if (take && !bus.we) begin
			case (bus.addr)
				ras_pkg::RAS_CTRL_ADDR: rdata_reg <= ctrl_reg;
				ras_pkg::RAS_STAT_ADDR: rdata_reg <= {4'h0, busy_reg,
					decrypt_reg, flag_a_reg, ready_reg};
				ras_pkg::RAS_TOPO_LO_ADDR: rdata_reg <= topo_reg[7:0];
				ras_pkg::RAS_TOPO_HI_ADDR: rdata_reg <= topo_reg[15:8];
				ras_pkg::RAS_HASH0_ADDR: rdata_reg <= hash_reg[7:0];
				ras_pkg::RAS_HASH0_ADDR + 8'h01: rdata_reg <= hash_reg[15:8];
				ras_pkg::RAS_HASH0_ADDR + 8'h02: rdata_reg <= hash_reg[23:16];
				ras_pkg::RAS_HASH0_ADDR + 8'h03: rdata_reg <= hash_reg[31:24];
				default: begin
					if (bus.addr[7]) begin
						rdata_reg <= list_mem[bus.addr[6:0]];
					end else begin
						rdata_reg <= 8'h00;
					end
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// vsync filter and decryption arming
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			vs_sync_reg <= 3'b000;
			vs_filt_reg <= 1'b0;
		end else begin
			vs_sync_reg <= {vs_sync_reg[1:0], bus.vsync};
			if (vs_sync_reg[1] == vs_sync_reg[2]) begin
				vs_filt_reg <= vs_sync_reg[2];
			end
		end
	end
	assign vs_fall = vs_filt_reg && !vs_sync_reg[1] && !vs_sync_reg[2];

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			decrypt_reg <= 1'b0;
		end else if (!ctrl_reg[ras_pkg::RAS_ENC_BIT]) begin
			decrypt_reg <= 1'b0;
		end else if (vs_fall) begin
			decrypt_reg <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// general-purpose pins
	// --------------------------------------------------------------
	assign bus.gpio0_o = ctrl_reg[ras_pkg::RAS_PIN0_SEL_BIT] &&
		ctrl_reg[ras_pkg::RAS_ENC_BIT];
	assign bus.gpio0_oe_n = !ctrl_reg[ras_pkg::RAS_PIN0_SEL_BIT];
	assign bus.gpio1_o = ctrl_reg[ras_pkg::RAS_PIN1_SEL_BIT] && flag_a_reg;
	assign bus.gpio1_oe_n = !ctrl_reg[ras_pkg::RAS_PIN1_SEL_BIT];

	assign o_decrypt_active = decrypt_reg;
	assign o_hash_busy = busy_reg;
endmodule

// ===== sim/ras_chk.sv
// carrier assertions for the receiver and controller pair
`timescale 1ns/10ps
module ras_chk (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// carrier
	input wire logic req,
	input wire logic src_up,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic vsync,
	input wire logic gpio0_o,
	input wire logic gpio0_oe_n,
	input wire logic gpio1_o,
	input wire logic gpio1_oe_n,
	// receiver status
	input wire logic o_decrypt_active,
	input wire logic o_hash_busy
);
	logic [7:0] ctrl_reg;
	logic [6:0] count_reg;
	logic [9:0] busy_len_reg;
	logic [3:0] since_fall_reg;
	logic wr_taken;
	assign wr_taken = req && we && (!src_up || ctrl_reg[0]);
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);
	// --------------------------------------------------------------
	// shadows of what the receiver has accepted
	// --------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_reg <= ras_pkg::RAS_CTRL_RST;
		end else if (wr_taken && addr == ras_pkg::RAS_CTRL_ADDR) begin
			ctrl_reg <= wdata;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count_reg <= 7'h00;
		end else if (wr_taken && addr == ras_pkg::RAS_TOPO_LO_ADDR) begin
			count_reg <= wdata[6:0];
		end
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_len_reg <= 10'h000;
		end else begin
			busy_len_reg <= o_hash_busy ? busy_len_reg + 10'h001 : 10'h000;
		end
	end
	// cycles since the last falling vsync, saturating
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			since_fall_reg <= 4'hf;
		end else if ($fell(vsync)) begin
			since_fall_reg <= 4'h0;
		end else if (since_fall_reg != 4'hf) begin
			since_fall_reg <= since_fall_reg + 4'h1;
		end
	end
	// --------------------------------------------------------------
	// properties
	// --------------------------------------------------------------
	property p_pass;
		req && src_up && ctrl_reg[0] && ctrl_reg[1] |=> ack;
	endproperty
	a_pass: assert property (p_pass)
		else $error("upstream request not answered while enabled");
	property p_block;
		req && src_up && !ctrl_reg[0] && !ctrl_reg[1] |=> !ack [*3];
	endproperty
	a_block: assert property (p_block)
		else $error("upstream request answered while blocked");
	property p_local;
		req && !src_up |=> ack;
	endproperty
	a_local: assert property (p_local)
		else $error("local request not answered");
	property p_ack_cause;
		ack |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("answer without request");
	property p_pin0_on;
		ctrl_reg[3] && $stable(ctrl_reg) |->
			!gpio0_oe_n && gpio0_o == ctrl_reg[2];
	endproperty
	a_pin0_on: assert property (p_pin0_on)
		else $error("pin zero does not follow encryption enable");
	property p_pin0_off;
		!ctrl_reg[3] && $stable(ctrl_reg) |-> gpio0_oe_n;
	endproperty
	a_pin0_off: assert property (p_pin0_off)
		else $error("pin zero driven while not selected");
	property p_pin1;
		wr_taken && addr == ras_pkg::RAS_TXKEY_LAST_ADDR && ctrl_reg[4]
			|-> ##[1:2] !gpio1_oe_n && gpio1_o;
	endproperty
	a_pin1: assert property (p_pin1)
		else $error("pin one not raised by key write");
	property p_dec_late;
		$rose(o_decrypt_active) |-> since_fall_reg inside {[4'h1:4'h7]};
	endproperty
	a_dec_late: assert property (p_dec_late)
		else $error("decryption started away from vsync fall");
	property p_dec_on;
		ctrl_reg[2] && $fell(vsync) |-> ##[1:8] o_decrypt_active;
	endproperty
	a_dec_on: assert property (p_dec_on)
		else $error("decryption not started after vsync fall");
	property p_hash_start;
		wr_taken && addr == ras_pkg::RAS_TOPO_HI_ADDR |-> ##[1:2] o_hash_busy;
	endproperty
	a_hash_start: assert property (p_hash_start)
		else $error("topology write did not start hash");
	property p_hash_len;
		$fell(o_hash_busy) |->
			busy_len_reg == 10'(count_reg) * 10'h005 + 10'h001;
	endproperty
	a_hash_len: assert property (p_hash_len)
		else $error("hash run length wrong");
	c_block: cover property (req && src_up && !ctrl_reg[0] ##1 !ack);
	c_dec: cover property ($rose(o_decrypt_active));
	c_hash: cover property ($fell(o_hash_busy));
endmodule

// ===== sim/ras_tb.sv
// bench: controller drives the receiver across the carrier
`timescale 1ns/10ps
module ras_tb;
	localparam logic [11:0] W_OK = 12'h400;
	localparam logic [11:0] W_REF = 12'h100;
	localparam logic [11:0] W_FAIL = 12'h200;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_cmd_valid = 1'b0;
	logic i_cmd_src_up = 1'b0;
	logic i_cmd_we = 1'b0;
	logic [7:0] i_cmd_addr = 8'h00;
	logic [7:0] i_cmd_wdata = 8'h00;
	logic [7:0] i_list_bytes = 8'h0a;
	logic i_hash_check = 1'b0;
	logic i_hash_match = 1'b0;
	logic i_revoked = 1'b0;
	logic o_decrypt_active, o_hash_busy, o_cmd_ready, o_done, o_fail;
	logic o_refused, o_pin1_seen, o_pin0_seen, o_auth_fail, o_protected_ok;
	logic [7:0] o_rdata;
	logic [11:0] exp_q[$];
	logic [11:0] note;
	logic [7:0] key[10];
	logic [7:0] secret, topo_hi;
	logic [31:0] hash;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	ras_if bus_if();
	ras_rx ras_rx_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(bus_if),
		.o_decrypt_active(o_decrypt_active), .o_hash_busy(o_hash_busy));
	ras_ctl ras_ctl_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(bus_if),
		.i_cmd_valid(i_cmd_valid), .i_cmd_src_up(i_cmd_src_up),
		.i_cmd_we(i_cmd_we), .i_cmd_addr(i_cmd_addr),
		.i_cmd_wdata(i_cmd_wdata), .o_cmd_ready(o_cmd_ready),
		.o_done(o_done), .o_fail(o_fail), .o_refused(o_refused),
		.o_rdata(o_rdata), .i_list_bytes(i_list_bytes),
		.i_hash_check(i_hash_check), .i_hash_match(i_hash_match),
		.i_revoked(i_revoked), .o_pin1_seen(o_pin1_seen),
		.o_pin0_seen(o_pin0_seen), .o_auth_fail(o_auth_fail),
		.o_protected_ok(o_protected_ok));
	ras_chk ras_chk_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.req(bus_if.req), .src_up(bus_if.src_up), .we(bus_if.we),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
		.rdata(bus_if.rdata), .vsync(bus_if.vsync),
		.gpio0_o(bus_if.gpio0_o), .gpio0_oe_n(bus_if.gpio0_oe_n),
		.gpio1_o(bus_if.gpio1_o), .gpio1_oe_n(bus_if.gpio1_oe_n),
		.o_decrypt_active(o_decrypt_active), .o_hash_busy(o_hash_busy));
	always #10 i_core_clk = ~i_core_clk;
	// --------------------------------------------------------------
	// checking and closing
	// --------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			end_of_test();
		end
	end
	// note layout: compare-rdata, done, fail, refused, rdata
	always @(negedge i_core_clk) begin
		if (o_done || o_fail || o_refused) begin
			note = (exp_q.size() != 0) ? exp_q.pop_front() : 12'hfff;
			check({o_done, o_fail, o_refused, note[11] ? o_rdata : 8'h00},
				note[10:0]);
		end
	end
	// --------------------------------------------------------------
	// drivers
	// --------------------------------------------------------------
	task automatic op(input logic up, input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [11:0] e);
		@(negedge i_core_clk);
		while (!o_cmd_ready) @(negedge i_core_clk);
		exp_q.push_back(e);
		@(posedge i_core_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_src_up <= up;
		i_cmd_we <= w;
		i_cmd_addr <= a;
		i_cmd_wdata <= d;
		@(posedge i_core_clk);
		i_cmd_valid <= 1'b0;
		while (exp_q.size() != 0) @(posedge i_core_clk);
	endtask
	task automatic vsync_pulse();
		@(posedge i_core_clk);
		bus_if.vsync <= 1'b0;
		repeat (12 + $urandom_range(20)) @(posedge i_core_clk);
		bus_if.vsync <= 1'b1;
		repeat (20) @(posedge i_core_clk);
	endtask
	task automatic hcheck(input logic m, input logic r);
		@(posedge i_core_clk);
		i_hash_check <= 1'b1;
		i_hash_match <= m;
		i_revoked <= r;
		@(posedge i_core_clk);
		i_hash_check <= 1'b0;
		repeat (4) @(negedge i_core_clk);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		bus_if.vsync = 1'b1;
		void'($urandom(32'he654_b424));
		for (int i = 0; i < 10; i++) begin
			key[i] = 8'($urandom());
		end
		secret = 8'($urandom());
		topo_hi = 8'($urandom()) & 8'h07;
		repeat (12) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		op(1'b0, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1b, W_OK);
		op(1'b1, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1b, W_OK);
		op(1'b1, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1f, W_REF);
		op(1'b1, 1'b1, ras_pkg::RAS_SECRET_ADDR, secret, W_OK);
		for (int i = 0; i < 5; i++) begin
			op(1'b1, 1'b1, ras_pkg::RAS_TXKEY0_ADDR + 8'(i),
				8'($urandom()), W_OK);
		end
		op(1'b0, 1'b0, ras_pkg::RAS_STAT_ADDR, 8'h00, 12'hc02);
		repeat (8) @(negedge i_core_clk);
		check(o_pin1_seen, 1);
		vsync_pulse();
		op(1'b1, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1f, W_OK);
		repeat (10) @(negedge i_core_clk);
		check(o_decrypt_active, 0);
		check(o_pin0_seen, 1);
		vsync_pulse();
		check(o_decrypt_active, 1);
		op(1'b0, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1c, W_OK);
		op(1'b0, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1f, W_REF);
		op(1'b1, 1'b0, ras_pkg::RAS_STAT_ADDR, 8'h00, W_FAIL);
		op(1'b0, 1'b1, ras_pkg::RAS_TOPO_LO_ADDR, 8'h02, W_OK);
		for (int i = 0; i < 5; i++) begin
			op(1'b0, 1'b1, 8'h80 + 8'(i), key[i], W_OK);
		end
		op(1'b0, 1'b1, ras_pkg::RAS_TOPO_HI_ADDR, topo_hi, W_REF);
		op(1'b0, 1'b1, ras_pkg::RAS_TOPO_LO_ADDR, 8'h02, W_OK);
		for (int i = 0; i < 10; i++) begin
			op(1'b0, 1'b1, 8'h80 + 8'(i), key[i], W_OK);
		end
		op(1'b0, 1'b1, ras_pkg::RAS_TOPO_HI_ADDR, topo_hi, W_OK);
		while (o_hash_busy) @(negedge i_core_clk);
		hash = ras_pkg::RAS_HASH_SEED;
		for (int i = 0; i < 10; i++) begin
			hash = {hash[26:0], hash[31:27]} ^ {24'h00_0000, key[i]};
		end
		hash = {hash[26:0], hash[31:27]} ^
			{24'h00_0000, 8'h02 ^ topo_hi ^ secret};
		for (int i = 0; i < 4; i++) begin
			op(1'b0, 1'b0, ras_pkg::RAS_HASH0_ADDR + 8'(i), 8'h00,
				{4'hc, hash[8 * i +: 8]});
		end
		op(1'b0, 1'b1, ras_pkg::RAS_STAT_ADDR, 8'h01, W_OK);
		op(1'b0, 1'b1, ras_pkg::RAS_CTRL_ADDR, 8'h1f, W_OK);
		op(1'b1, 1'b0, ras_pkg::RAS_STAT_ADDR, 8'h00, 12'hc05);
		op(1'b1, 1'b0, ras_pkg::RAS_TOPO_LO_ADDR, 8'h00, 12'hc02);
		hcheck(1'b0, 1'b0);
		hcheck(1'b0, 1'b0);
		check(o_auth_fail, 0);
		hcheck(1'b1, 1'b1);
		check(o_protected_ok, 0);
		hcheck(1'b1, 1'b0);
		check(o_protected_ok, 1);
		op(1'b0, 1'b1, ras_pkg::RAS_TOPO_LO_ADDR, 8'h80, W_OK);
		op(1'b1, 1'b0, ras_pkg::RAS_TOPO_LO_ADDR, 8'h00, 12'hc80);
		repeat (2) @(negedge i_core_clk);
		check(o_auth_fail, 1);
		check(o_protected_ok, 0);
		// second reset, then three failed compares
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			hcheck(1'b0, 1'b0);
		end
		check(o_auth_fail, 1);
		end_of_test();
	end
endmodule
